//--- flash_protection_map.svh
// Functional notes
// - flash is split into 768-byte sectors; protection counts whole sectors.
// - only security pattern 1:0 is unsecured; key match or blank check unsecures.
// - key enable clear: key window writes start program or erase commands.
// - key enable set (config bit 5): key window program writes load comparison key.
// - protection register loads from its nonvolatile image during reset.
// - protection readable always; writes only keep or grow the region.
// - program or erase inside protected area is refused and flags violation.
// - mass erase is refused while any sector is protected.
// - protect select is bits 5:0; bits 7:6 reserved; 0x3F protects none.
// - lower selects protect up to 0xFFFF; 0x3E two, 0x1F 64 sectors.
// - while secured, non-secure RAM access is blocked.
`ifndef FLASH_PROTECTION_MAP_SVH
`define FLASH_PROTECTION_MAP_SVH

// register byte offsets
`define OFS_CONFIG 8'h00
`define OFS_PROTECT 8'h04
`define OFS_STATUS 8'h08
`define OFS_INT_MASK 8'h0C

// field positions and values
`define CFG_KEY_WRITE_EN_BIT 5
`define CFG_RESET 8'h00
`define PROT_SELECT_MSB 5
`define PROT_NONE 6'h3F
`define STAT_VIOL_BIT 0
`define STAT_KEY_FAIL_BIT 1
`define STAT_SEC_LSB 4
`define STAT_EVENT_MASK 8'h03
`define SEC_UNSECURED 2'h2

// flash geometry
`define SECTOR_BYTES 18'h00300
`define FLASH_TOP_PLUS1 18'h10000
`define KEY_WINDOW_TAG 13'h1FF6

// command kinds from the core
`define KIND_PROGRAM 2'h0
`define KIND_SECTOR_ERASE 2'h1
`define KIND_MASS_ERASE 2'h2

`endif

//--- flash_protection_pkg.sv
package flash_protection_pkg;

  typedef enum logic [0:0] {
    KEY_COLLECT = 1'b0,
    KEY_COMPARE = 1'b1
  } keyState_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [7:0] config_reg;
    logic [5:0] protect;
    logic [7:0] status;
    logic [7:0] intMask;
    logic [1:0] security;
    logic ramBlocked;
    logic irq;
    logic cmdStart;
    logic [15:0] cmdAddr;
    logic [7:0] cmdData;
    logic [1:0] cmdKind;
    keyState_t keyState;
    logic [7:0] keyWritten;
    logic [7:0][7:0] keySlots;
  } state_t;

endpackage

//--- flash_protection_security.sv
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ns
`include "flash_protection_map.svh"

module flash_protection_security (
  input wire logic ref_clk,
  input wire logic rst,
  // apb slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // flash write path from the core
  input wire logic flashWrStrobe,
  input wire logic [15:0] flashWrAddr,
  input wire logic [7:0] flashWrData,
  input wire logic [1:0] flashWrKind,
  // nonvolatile images and array status
  input wire logic [7:0] protectionNvImage,
  input wire logic [1:0] securityNvImage,
  input wire logic [63:0] backdoorKeyNv,
  input wire logic blankCheckOk,
  // command launch toward the flash controller
  output logic cmdStart,
  output logic [15:0] cmdAddr,
  output logic [7:0] cmdData,
  output logic [1:0] cmdKind,
  output logic [1:0] securityState,
  output logic ramAccessBlocked,
  output logic irq
);

  flash_protection_pkg::state_t s;
  flash_protection_pkg::state_t n;
  logic [7:0] keyByteOk;
  logic [17:0] protSize;
  logic addrProtected;
  logic inKeyWindow;
  logic anyProtected;
  logic apbAccess;
  logic apbWrite;
  logic addrHit;
  logic [31:0] readMux;
  logic [7:0] eventSet;
  logic [7:0] eventClr;

  // one comparator per key byte against the stored image
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : gKey
      assign keyByteOk[gi] = s.keySlots[gi] == backdoorKeyNv[8*gi +: 8];
    end
  endgenerate

  // region size: two sectors per step below the no-protection code
  // 18 bits so that selects below 0x15 simply cover the whole array
  assign protSize = 18'({12'h000, `PROT_NONE - s.protect}) *
    (`SECTOR_BYTES << 1);
  assign anyProtected = s.protect != `PROT_NONE;
  assign addrProtected = anyProtected &&
    ({2'b00, flashWrAddr} + protSize) >= `FLASH_TOP_PLUS1;
  assign inKeyWindow = flashWrAddr[15:3] == `KEY_WINDOW_TAG;

  // bus decode and read mux; reserved bits read as zero
  assign apbAccess = psel & penable;
  assign apbWrite = apbAccess & s.pready & pwrite;
  always_comb begin
    addrHit = 1'b1;
    readMux = 32'h00000000;
    case (paddr)
      `OFS_CONFIG: readMux = {24'h000000, s.config_reg};
      `OFS_PROTECT: readMux = {26'h0000000, s.protect};
      `OFS_STATUS: begin
        readMux = {24'h000000, s.status};
        readMux[`STAT_SEC_LSB +: 2] = s.security;
      end
      `OFS_INT_MASK: readMux = {24'h000000, s.intMask};
      default: addrHit = 1'b0;
    endcase
  end

  // next state of the whole block
  always_comb begin
    n = s;
    n.cmdStart = 1'b0;
    eventSet = 8'h00;
    eventClr = 8'h00;

    // one wait state: pready rises in the second access cycle
    n.pready = apbAccess & ~s.pready;
    if (apbAccess & ~s.pready) begin
      n.prdata = pwrite ? 32'h00000000 : readMux;
      n.pslverr = ~addrHit;
    end else begin
      n.prdata = 32'h00000000;
      n.pslverr = 1'b0;
    end

    // software register writes, taken on the completing edge
    if (apbWrite) begin
      case (paddr)
        `OFS_CONFIG: n.config_reg = pwdata[7:0];
        `OFS_PROTECT: begin
          // a lower select means a larger region; shrinking is dropped
          if (pwdata[`PROT_SELECT_MSB:0] <= s.protect) begin
            n.protect = pwdata[`PROT_SELECT_MSB:0];
          end
        end
        `OFS_STATUS: eventClr = pwdata[7:0] & `STAT_EVENT_MASK;
        `OFS_INT_MASK: n.intMask = pwdata[7:0] & `STAT_EVENT_MASK;
        default: ;
      endcase
    end

    // flash writes from the core
    if (flashWrStrobe) begin
      if (s.config_reg[`CFG_KEY_WRITE_EN_BIT] && inKeyWindow &&
          flashWrKind == `KIND_PROGRAM &&
          s.keyState == flash_protection_pkg::KEY_COLLECT) begin
        // key bytes land in slots, no command is launched
        n.keySlots[flashWrAddr[2:0]] = flashWrData;
        n.keyWritten[flashWrAddr[2:0]] = 1'b1;
        if ((s.keyWritten | (8'h01 << flashWrAddr[2:0])) == 8'hFF) begin
          n.keyState = flash_protection_pkg::KEY_COMPARE;
        end
      end else if (flashWrKind == `KIND_MASS_ERASE) begin
        if (anyProtected) begin
          eventSet[`STAT_VIOL_BIT] = 1'b1;
        end else begin
          n.cmdStart = 1'b1;
        end
      end else if (addrProtected) begin
        eventSet[`STAT_VIOL_BIT] = 1'b1;
      end else begin
        // with key enable clear the key window is ordinary flash
        n.cmdStart = 1'b1;
      end
      if (n.cmdStart) begin
        n.cmdAddr = flashWrAddr;
        n.cmdData = flashWrData;
        n.cmdKind = flashWrKind;
      end
    end

    // compare a full key one cycle after the last byte arrives
    if (s.keyState == flash_protection_pkg::KEY_COMPARE) begin
      if (&keyByteOk) begin
        n.security = `SEC_UNSECURED;
      end else begin
        eventSet[`STAT_KEY_FAIL_BIT] = 1'b1;
      end
      n.keyWritten = 8'h00;
      n.keyState = flash_protection_pkg::KEY_COLLECT;
    end
    if (blankCheckOk) begin
      n.security = `SEC_UNSECURED;
    end

    // sticky events: a set in the clearing cycle survives
    n.status = (s.status & ~eventClr) | eventSet;
    n.ramBlocked = n.security != `SEC_UNSECURED;
    n.irq = |(n.status & n.intMask);

    // synchronous reset loads the nonvolatile images
    if (rst) begin
      n.pready = 1'b0;
      n.pslverr = 1'b0;
      n.prdata = 32'h00000000;
      n.config_reg = `CFG_RESET;
      n.protect = protectionNvImage[`PROT_SELECT_MSB:0];
      n.status = 8'h00;
      n.intMask = 8'h00;
      n.security = securityNvImage;
      n.ramBlocked = securityNvImage != `SEC_UNSECURED;
      n.irq = 1'b0;
      n.cmdStart = 1'b0;
      n.cmdAddr = 16'h0000;
      n.cmdData = 8'h00;
      n.cmdKind = `KIND_PROGRAM;
      n.keyState = flash_protection_pkg::KEY_COLLECT;
      n.keyWritten = 8'h00;
      n.keySlots = 64'h0000000000000000;
    end
  end

  // single state register
  always_ff @(posedge ref_clk) begin
    s <= n;
  end

  // outputs come straight from the state flops
  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign cmdStart = s.cmdStart;
  assign cmdAddr = s.cmdAddr;
  assign cmdData = s.cmdData;
  assign cmdKind = s.cmdKind;
  assign securityState = s.security;
  assign ramAccessBlocked = s.ramBlocked;
  assign irq = s.irq;

endmodule

//--- fps_props.sv
`timescale 1ns/1ns
module fps_props (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  input wire logic flashWrStrobe,
  input wire logic [15:0] flashWrAddr,
  input wire logic blankCheckOk,
  input wire logic cmdStart,
  input wire logic [15:0] cmdAddr,
  input wire logic [1:0] securityState,
  input wire logic ramAccessBlocked
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // bus answers after exactly one wait state, for one cycle
  a_one_wait: assert property (psel && !penable ##1 penable |->
    !pready ##1 pready) else $error("pready not after one wait");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_data_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero when idle");
  // a command only ever follows a core write to the same place
  a_cmd_cause: assert property (cmdStart |-> $past(flashWrStrobe) &&
    cmdAddr == $past(flashWrAddr)) else $error("command without cause");
  a_blank_unsec: assert property (blankCheckOk |=>
    securityState == 2'h2) else $error("blank check did not unsecure");
  a_ram_block: assert property (ramAccessBlocked ==
    (securityState != 2'h2)) else $error("ram block wrong");
  // outside reset, security can only move to the unsecured code
  a_sec_move: assert property ($changed(securityState) |->
    securityState == 2'h2) else $error("security moved wrongly");
  c_cmd: cover property (cmdStart);
  c_err: cover property (pslverr);
  c_unsec: cover property ($fell(ramAccessBlocked));
endmodule
bind flash_protection_security fps_props u_props (.*);

//--- core_model.sv
`timescale 1ns/1ns
module core_model (
  input wire logic clk,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic [7:0] paddr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] pwdata,
  output logic flashWrStrobe,
  output logic [15:0] flashWrAddr,
  output logic [7:0] flashWrData,
  output logic [1:0] flashWrKind
);
  initial begin
    {paddr, psel, penable, pwrite, pwdata, flashWrStrobe} = '0;
    {flashWrAddr, flashWrData, flashWrKind} = '0;
  end
  // apb master; on release psel and penable drop to zero, paddr and pwdata show inverted values; pwrite keeps its last one
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    // no cycle count assumed: waits for pready; only the bench watchdog bounds this wait
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    {psel, penable, paddr, pwdata} <= {2'h0, ~a, ~d};
  endtask
  // one core write into flash space, strobe held for one cycle
  task automatic fwr(input logic [15:0] a, input logic [7:0] d,
      input logic [1:0] k);
    @(posedge clk);
    {flashWrStrobe, flashWrAddr, flashWrData, flashWrKind} <= {1'b1, a, d, k};
    @(posedge clk);
    {flashWrStrobe, flashWrAddr, flashWrData} <= {1'b0, ~a, ~d};
  endtask
endmodule

//--- testbench.sv
`timescale 1ns/1ns
module testbench;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic blankCheckOk = 1'b0;
  logic [7:0] protection_nv_image = 8'h3F;
  logic [1:0] nvSec = 2'h3;
  logic [63:0] keyNv = 64'h0123456789ABCDEF;
  logic psel, penable, pwrite, pready, pslverr, flashWrStrobe, err;
  logic cmdStart, ramAccessBlocked, irq;
  logic [7:0] paddr, flashWrData, cmdData;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] flashWrAddr, cmdAddr;
  logic [1:0] flashWrKind, cmdKind, securityState;
  int fails = 0;
  int checks_done = 0;
  always #10 ref_clk = ~ref_clk;
  flash_protection_security dut (.ref_clk, .rst, .paddr, .psel, .penable,
    .pwrite, .pwdata, .prdata, .pready, .pslverr, .flashWrStrobe,
    .flashWrAddr, .flashWrData, .flashWrKind, .protectionNvImage(protection_nv_image),
    .securityNvImage(nvSec), .backdoorKeyNv(keyNv), .blankCheckOk,
    .cmdStart, .cmdAddr, .cmdData, .cmdKind, .securityState,
    .ramAccessBlocked, .irq);
  core_model core (.clk(ref_clk), .prdata, .pready, .pslverr, .paddr,
    .psel, .penable, .pwrite, .pwdata, .flashWrStrobe, .flashWrAddr,
    .flashWrData, .flashWrKind);
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    checks_done++;
    if (g !== x) begin
      fails++;
      $display("Error at %0t: got %0h expected %0h", $time, g, x);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    core.apb(1'b1, a, d, rd, err);
    #1;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    core.apb(1'b0, a, 32'h0, rd, err);
    chk(rd, x);
  endtask
  // core write, then the command pulse seen one cycle on
  task automatic fw(input logic [15:0] a, input logic [7:0] d,
      input logic [1:0] k, input logic x);
    core.fwr(a, d, k);
    #1;
    chk(cmdStart, x);
  endtask
  task automatic do_reset(input logic [7:0] p, input logic [1:0] s);
    @(posedge ref_clk);
    {rst, protection_nv_image, nvSec} <= {1'b1, p, s};
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
  endtask
  task automatic t_key;
    fw(16'hFFB3, 8'h5A, 2'h0, 1'b1);
    wr(8'h00, 32'h20);
    for (int i = 0; i < 8; i++) fw(16'hFFB0 + 16'(i), 8'h5A, 2'h0, 1'b0);
    @(posedge ref_clk);
    #1;
    chk(securityState, 2'h3);
    rdc(8'h08, 32'h32);
    for (int i = 0; i < 8; i++) fw(16'hFFB0 + 16'(i), keyNv[8*i+:8], 2'h0, 1'b0);
    @(posedge ref_clk);
    #1;
    chk(securityState, 2'h2);
    chk(ramAccessBlocked, 1'b0);
    $display("key test done");
  endtask
  task automatic t_blank;
    do_reset(8'h3F, 2'h0);
    chk(ramAccessBlocked, 1'b1);
    @(posedge ref_clk) blankCheckOk <= 1'b1;
    @(posedge ref_clk) blankCheckOk <= 1'b0;
    #1;
    chk(securityState, 2'h2);
    $display("blank test done");
  endtask
  task automatic t_regs;
    rdc(8'h00, 32'h0);
    rdc(8'h04, 32'h3F);
    core.apb(1'b0, 8'h10, 32'h0, rd, err);
    chk(err, 1'b1);
    wr(8'h04, 32'h3C);
    rdc(8'h04, 32'h3C);
    wr(8'h04, 32'h3D);
    rdc(8'h04, 32'h3C);
    $display("register test done");
  endtask
  // the 0x3C region starts 6 sectors of 0x300 below the top
  task automatic t_protect;
    fw(16'hEE00, 8'h00, 2'h1, 1'b0);
    fw(16'hEDFF, 8'hA5, 2'h0, 1'b1);
    chk({cmdAddr, cmdData, cmdKind}, {16'hEDFF, 8'hA5, 2'h0});
    fw(16'h0000, 8'h00, 2'h2, 1'b0);
    chk(irq, 1'b0);
    wr(8'h0C, 32'h1);
    chk(irq, 1'b1);
    wr(8'h08, 32'h1);
    chk(irq, 1'b0);
    wr(8'h04, 32'h2D);
    fw(16'h9400, 8'h00, 2'h1, 1'b0);
    fw(16'h93FF, 8'h00, 2'h1, 1'b1);
    // a reprogrammed image takes effect at the next reset
    do_reset(8'hFE, 2'h3);
    rdc(8'h04, 32'h3E);
    $display("protect test done");
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    do_reset(8'h3F, 2'h3);
    t_key;
    t_blank;
    do_reset(8'h3F, 2'h3);
    t_regs;
    t_protect;
    stop_test;
  end
  // the whole run needs well under a tenth of this span
  initial begin
    #200000;
    fails++;
    stop_test;
  end
endmodule
